// ==== pkg/csm_pkg.sv ====
package csm_pkg;

    // ************************************************************
    // page decode
    // ************************************************************
    localparam logic [7:0] CAN_PAGE = 8'h0c;

    // ************************************************************
    // processor-side addresses of each byte register
    // ************************************************************
    localparam logic [7:0] A_CONTROL      = 8'hc0;
    localparam logic [7:0] A_STATUS       = 8'h94;
    localparam logic [7:0] A_ERR_L        = 8'h96;
    localparam logic [7:0] A_ERR_H        = 8'h97;
    localparam logic [7:0] A_BT_L         = 8'h9a;
    localparam logic [7:0] A_BT_H         = 8'h9b;
    localparam logic [7:0] A_IID_L        = 8'h9c;
    localparam logic [7:0] A_IID_H        = 8'h9d;
    localparam logic [7:0] A_TEST         = 8'h9e;
    localparam logic [7:0] A_BRPE         = 8'ha1;
    localparam logic [7:0] A_CLK_CFG      = 8'h92;

    // ************************************************************
    // controller-side word offset and processor addresses of the
    // interface registers, low byte address first
    // ************************************************************
    localparam int N_IFR = 19;
    localparam logic [7:0] IFR_CAN_ADDR [N_IFR] = '{
        8'h10, 8'h12, 8'h14, 8'h16, 8'h18, 8'h1a, 8'h1c, 8'h1e, 8'h20,
        8'h22, 8'h24, 8'h40, 8'h42, 8'h44, 8'h46, 8'h48, 8'h4a, 8'h4c, 8'h4e};
    localparam logic [7:0] IFR_LO_ADDR [N_IFR] = '{
        8'hbe, 8'hc2, 8'hc4, 8'hc6, 8'hca, 8'hcc, 8'hd2, 8'hd4, 8'hd6,
        8'hda, 8'hdc, 8'hde, 8'he2, 8'hea, 8'hec, 8'hee, 8'hf2, 8'hce, 8'hf6};
    localparam logic [7:0] IFR_HI_ADDR [N_IFR] = '{
        8'hbf, 8'hc3, 8'hc5, 8'hc7, 8'hcb, 8'hcd, 8'hd3, 8'hd5, 8'hd7,
        8'hdb, 8'hdd, 8'hdf, 8'he3, 8'heb, 8'hed, 8'hef, 8'hf3, 8'hcf, 8'hf7};
    localparam logic [15:0] IFR_RESET [N_IFR] = '{
        16'h0001, 16'h0000, 16'hffff, 16'hffff, 16'h0000, 16'h0000, 16'h0000,
        16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0001, 16'h0000, 16'hffff,
        16'hffff, 16'h0000, 16'h0000, 16'h0000, 16'h0000};

    // ************************************************************
    // controller register offsets
    // ************************************************************
    localparam logic [7:0] C_CONTROL = 8'h00;
    localparam logic [7:0] C_STATUS  = 8'h02;
    localparam logic [7:0] C_BT      = 8'h06;
    localparam logic [7:0] C_TEST    = 8'h0a;
    localparam logic [7:0] C_BRPE    = 8'h0c;

    // ************************************************************
    // reset values and fields
    // ************************************************************
    localparam logic [7:0]  RST_CONTROL = 8'h01;
    localparam logic [7:0]  RST_STATUS  = 8'h00;
    localparam logic [15:0] RST_BT      = 16'h2301;
    localparam logic [7:0]  RST_TEST    = 8'h00;
    localparam logic [7:0]  RST_BRPE    = 8'h00;
    localparam logic [7:0]  RST_CLK_CFG = 8'h00;
    localparam int          CFG_CHG_BIT = 6;
    localparam int          TEST_BIT    = 7;
    localparam int          RX_BIT      = 7;

    // one processor access
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } csm_sfr_req_s;

    // one write passed on to the controller core
    typedef struct packed {
        logic       wr;
        logic [7:0] addr;
        logic [1:0] byte_en;
        logic [15:0] data;
    } csm_core_wr_s;

endpackage : csm_pkg

// ==== logic/csm_can_sfr_map.sv ====
`timescale 1ns/10ps
// Summary of operation
// - every controller register is readable from the processor register space; all but error count and interrupt id are writable
// - controller registers and clock config decode only when page select holds 0x0c
// - one extra byte register configures the controller clock
// - test register reset reads zero, or receive pin level in bit 7
// - bit timing and prescaler extension writes need config change enable set
module csm_can_sfr_map (
    input  wire logic                  core_clk,
    input  wire logic                  rst,
    input  wire logic [7:0]            register_page_select,
    input  wire csm_pkg::csm_sfr_req_s sfr_req,
    output logic [7:0]                 sfr_rdata,
    output logic                       sfr_hit,
    input  wire logic [15:0]           core_err_count,
    input  wire logic [15:0]           core_int_id,
    input  wire logic [7:0]            core_status,
    input  wire logic                  core_status_load,
    input  wire logic                  can_rx,
    output csm_pkg::csm_core_wr_s      core_wr,
    output logic [7:0]                 control_out,
    output logic [15:0]                bit_timing_out,
    output logic [7:0]                 prescaler_ext_out,
    output logic [7:0]                 test_out,
    output logic [7:0]                 can_clock_config
);

    // ************************************************************
    // decode
    // ************************************************************
    logic        page_ok;
    logic        wr_en;
    logic        rd_en;
    logic        cfg_chg_en;
    logic [7:0]  can_control_r;
    logic [7:0]  can_status_r;
    logic [15:0] bit_timing_r;
    logic [7:0]  test_control_r;
    logic [7:0]  prescaler_extension_r;
    logic [7:0]  can_clock_config_r;
    logic [15:0] ifr_r [csm_pkg::N_IFR];
    logic [7:0]  rdata_nxt;
    logic        hit_nxt;

    assign page_ok = (register_page_select == csm_pkg::CAN_PAGE);
    assign wr_en   = page_ok && sfr_req.wr;
    assign rd_en   = page_ok && sfr_req.rd;
    assign cfg_chg_en = can_control_r[csm_pkg::CFG_CHG_BIT];

    // ************************************************************
    // single byte registers
    // ************************************************************
    always_ff @(posedge core_clk) begin
        if (rst) begin
            can_control_r <= csm_pkg::RST_CONTROL;
        end else if (wr_en && sfr_req.addr == csm_pkg::A_CONTROL) begin
            can_control_r <= sfr_req.wdata;
        end
    end

    // status is written by software and reloaded by the core; core wins
    always_ff @(posedge core_clk) begin
        if (rst) begin
            can_status_r <= csm_pkg::RST_STATUS;
        end else if (core_status_load) begin
            can_status_r <= core_status;
        end else if (wr_en && sfr_req.addr == csm_pkg::A_STATUS) begin
            can_status_r <= sfr_req.wdata;
        end
    end

    // test register only writable while test mode is on in control
    always_ff @(posedge core_clk) begin
        if (rst) begin
            test_control_r <= csm_pkg::RST_TEST;
        end else if (wr_en && sfr_req.addr == csm_pkg::A_TEST
                     && can_control_r[csm_pkg::TEST_BIT]) begin
            test_control_r <= {1'b0, sfr_req.wdata[6:0]};
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            prescaler_extension_r <= csm_pkg::RST_BRPE;
        end else if (wr_en && cfg_chg_en && sfr_req.addr == csm_pkg::A_BRPE) begin
            prescaler_extension_r <= sfr_req.wdata;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            can_clock_config_r <= csm_pkg::RST_CLK_CFG;
        end else if (wr_en && sfr_req.addr == csm_pkg::A_CLK_CFG) begin
            can_clock_config_r <= sfr_req.wdata;
        end
    end

    // ************************************************************
    // split word registers
    // ************************************************************
    always_ff @(posedge core_clk) begin
        if (rst) begin
            bit_timing_r <= csm_pkg::RST_BT;
        end else if (wr_en && cfg_chg_en) begin
            if (sfr_req.addr == csm_pkg::A_BT_L) begin
                bit_timing_r[7:0] <= sfr_req.wdata;
            end else if (sfr_req.addr == csm_pkg::A_BT_H) begin
                bit_timing_r[15:8] <= sfr_req.wdata;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            for (int i = 0; i < csm_pkg::N_IFR; i++) begin
                ifr_r[i] <= csm_pkg::IFR_RESET[i];
            end
        end else if (wr_en) begin
            for (int i = 0; i < csm_pkg::N_IFR; i++) begin
                if (sfr_req.addr == csm_pkg::IFR_LO_ADDR[i]) begin
                    ifr_r[i][7:0] <= sfr_req.wdata;
                end
                if (sfr_req.addr == csm_pkg::IFR_HI_ADDR[i]) begin
                    ifr_r[i][15:8] <= sfr_req.wdata;
                end
            end
        end
    end

    // ************************************************************
    // write forwarding to the controller core
    // ************************************************************
    always_ff @(posedge core_clk) begin
        if (rst) begin
            core_wr <= '0;
        end else begin
            core_wr <= '0;
            if (wr_en) begin
                unique case (sfr_req.addr)
                    csm_pkg::A_CONTROL: begin
                        core_wr <= '{1'b1, csm_pkg::C_CONTROL, 2'b01,
                                     {8'h00, sfr_req.wdata}};
                    end
                    csm_pkg::A_STATUS: begin
                        core_wr <= '{1'b1, csm_pkg::C_STATUS, 2'b01,
                                     {8'h00, sfr_req.wdata}};
                    end
                    csm_pkg::A_BT_L: begin
                        core_wr <= '{cfg_chg_en, csm_pkg::C_BT, 2'b01, {8'h00, sfr_req.wdata}};
                    end
                    csm_pkg::A_BT_H: begin
                        core_wr <= '{cfg_chg_en, csm_pkg::C_BT, 2'b10, {sfr_req.wdata, 8'h00}};
                    end
                    csm_pkg::A_BRPE: begin
                        core_wr <= '{cfg_chg_en, csm_pkg::C_BRPE, 2'b01,
                                     {8'h00, sfr_req.wdata}};
                    end
                    default: begin
                        for (int i = 0; i < csm_pkg::N_IFR; i++) begin
                            if (sfr_req.addr == csm_pkg::IFR_LO_ADDR[i]) begin
                                core_wr <= '{1'b1, csm_pkg::IFR_CAN_ADDR[i], 2'b01,
                                             {8'h00, sfr_req.wdata}};
                            end
                            if (sfr_req.addr == csm_pkg::IFR_HI_ADDR[i]) begin
                                core_wr <= '{1'b1, csm_pkg::IFR_CAN_ADDR[i], 2'b10,
                                             {sfr_req.wdata, 8'h00}};
                            end
                        end
                    end
                endcase
            end
        end
    end

    // ************************************************************
    // read mux
    // ************************************************************
    always_comb begin
        rdata_nxt = 8'h00;
        hit_nxt   = 1'b1;
        case (sfr_req.addr)
            csm_pkg::A_CONTROL: rdata_nxt = can_control_r;
            csm_pkg::A_STATUS:  rdata_nxt = can_status_r;
            csm_pkg::A_ERR_L:   rdata_nxt = core_err_count[7:0];
            csm_pkg::A_ERR_H:   rdata_nxt = core_err_count[15:8];
            csm_pkg::A_BT_L:    rdata_nxt = bit_timing_r[7:0];
            csm_pkg::A_BT_H:    rdata_nxt = bit_timing_r[15:8];
            csm_pkg::A_IID_L:   rdata_nxt = core_int_id[7:0];
            csm_pkg::A_IID_H:   rdata_nxt = core_int_id[15:8];
            // bit 7 shows the live receive level, the variant allowed at reset
            csm_pkg::A_TEST:    rdata_nxt = {can_rx, test_control_r[6:0]};
            csm_pkg::A_BRPE:    rdata_nxt = prescaler_extension_r;
            csm_pkg::A_CLK_CFG: rdata_nxt = can_clock_config_r;
            default: begin
                hit_nxt = 1'b0;
                for (int i = 0; i < csm_pkg::N_IFR; i++) begin
                    if (sfr_req.addr == csm_pkg::IFR_LO_ADDR[i]) begin
                        rdata_nxt = ifr_r[i][7:0];
                        hit_nxt   = 1'b1;
                    end
                    if (sfr_req.addr == csm_pkg::IFR_HI_ADDR[i]) begin
                        rdata_nxt = ifr_r[i][15:8];
                        hit_nxt   = 1'b1;
                    end
                end
            end
        endcase
    end

    // read data registered; off page the block answers zero and no hit
    always_ff @(posedge core_clk) begin
        if (rst) begin
            sfr_rdata <= 8'h00;
            sfr_hit   <= 1'b0;
        end else begin
            sfr_rdata <= (rd_en && hit_nxt) ? rdata_nxt : 8'h00;
            sfr_hit   <= page_ok && hit_nxt && (sfr_req.rd || sfr_req.wr);
        end
    end

    assign control_out       = can_control_r;
    assign bit_timing_out    = bit_timing_r;
    assign prescaler_ext_out = prescaler_extension_r;
    assign test_out          = test_control_r;
    assign can_clock_config  = can_clock_config_r;

endmodule : csm_can_sfr_map

// ==== testbench/csm_can_sfr_map_chk.sv ====
`timescale 1ns/10ps
module csm_can_sfr_map_chk (
    input logic                  core_clk,
    input logic                  rst,
    input logic [7:0]            register_page_select,
    input csm_pkg::csm_sfr_req_s sfr_req,
    input logic [7:0]            sfr_rdata,
    input logic                  sfr_hit,
    input logic                  can_rx,
    input csm_pkg::csm_core_wr_s core_wr,
    input logic [7:0]            control_out,
    input logic [15:0]           bit_timing_out,
    input logic [7:0]            prescaler_ext_out,
    input logic [7:0]            test_out,
    input logic [7:0]            can_clock_config
);
    // ****************
    // access relations
    // ****************
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    logic       pg;
    logic       cfg_chg_en;
    logic       wr;
    logic [7:0] a;
    logic [7:0] bt_hi;
    logic [6:0] tst_lo;
    assign pg = register_page_select == csm_pkg::CAN_PAGE;
    assign cfg_chg_en = control_out[csm_pkg::CFG_CHG_BIT];
    assign wr = pg && sfr_req.wr;
    assign a = sfr_req.addr;
    assign bt_hi = bit_timing_out[15:8];
    assign tst_lo = test_out[6:0];
    AST_OFF_PAGE: assert property ((sfr_req.wr || sfr_req.rd) && !pg |=>
        !sfr_hit && sfr_rdata == 8'h00 && !core_wr.wr) else $error("off-page access acted");
    AST_CTRL_WR: assert property (wr && a == csm_pkg::A_CONTROL |=> sfr_hit && core_wr.wr
        && control_out == $past(sfr_req.wdata) && core_wr.addr == csm_pkg::C_CONTROL)
        else $error("control write not taken");
    AST_BT_HOLD: assert property (wr && !cfg_chg_en && a inside {8'h9a, 8'h9b} |=>
        $stable(bit_timing_out) && !core_wr.wr) else $error("bit timing changed while locked");
    AST_BT_LOAD: assert property (wr && cfg_chg_en && a == csm_pkg::A_BT_L |=>
        bit_timing_out == {$past(bt_hi), $past(sfr_req.wdata)}) else $error("bit timing low bad");
    AST_BRPE_HOLD: assert property (wr && !cfg_chg_en && a == csm_pkg::A_BRPE |=>
        $stable(prescaler_ext_out)) else $error("prescaler extension changed while locked");
    AST_CLK_CFG: assert property (wr && a == csm_pkg::A_CLK_CFG |=> sfr_hit &&
        can_clock_config == $past(sfr_req.wdata)) else $error("clock config write not taken");
    AST_TEST_RD: assert property (pg && sfr_req.rd && a == csm_pkg::A_TEST |=>
        sfr_rdata == {$past(can_rx), $past(tst_lo)}) else $error("test register read bad");
    AST_RESET_VAL: assert property ($fell(rst) |-> control_out == csm_pkg::RST_CONTROL &&
        bit_timing_out == csm_pkg::RST_BT && test_out == 8'h00 && can_clock_config == 8'h00)
        else $error("reset value wrong");
    cover property (wr && cfg_chg_en && a == csm_pkg::A_BT_L);
    cover property (sfr_req.wr && !pg);
    cover property (pg && sfr_req.rd && a == csm_pkg::A_TEST);
endmodule : csm_can_sfr_map_chk

bind csm_can_sfr_map csm_can_sfr_map_chk u_chk (.core_clk, .rst, .register_page_select,
    .sfr_req, .sfr_rdata, .sfr_hit, .can_rx, .core_wr, .control_out, .bit_timing_out,
    .prescaler_ext_out, .test_out, .can_clock_config);

// ==== testbench/csm_core_model.sv ====
`timescale 1ns/10ps
// controller core stand-in: its counters move on every forwarded write so reads see live values
module csm_core_model (
    input wire logic                  core_clk,
    input wire logic                  rst,
    input wire csm_pkg::csm_core_wr_s core_wr,
    output logic [15:0]               err_count,
    output logic [15:0]               int_id,
    output logic                      can_rx
);
    always_ff @(posedge core_clk) begin
        if (rst) begin
            err_count <= 16'h0000;
            int_id <= 16'h0000;
            can_rx <= 1'b1;
        end else if (core_wr.wr) begin
            err_count <= err_count + 16'h0001;
            int_id <= core_wr.data ^ {8'h00, core_wr.addr};
            can_rx <= ~can_rx;
        end
    end
endmodule : csm_core_model

// ==== testbench/test_can_sfr_register_map.sv ====
`timescale 1ns/10ps
module test_can_sfr_register_map;
    logic                  core_clk = 1'b0;
    logic                  rst = 1'b1;
    logic [7:0]            page = 8'h00;
    csm_pkg::csm_sfr_req_s req = '0;
    csm_pkg::csm_core_wr_s cwr;
    logic [7:0]            rdata, ctl, tst, brpe, ccfg, v;
    logic [15:0]           err, iid, bt;
    logic                  hit, rx;
    int                    bad_count = 0;
    int                    cmp_count = 0;
    integer                seed = 32'hd2ed385a;
    logic [7:0]            m [256];
    bit                    mp [256];
    int                    i, k;
    logic [7:0] regs [11] = '{csm_pkg::A_CONTROL, csm_pkg::A_STATUS, csm_pkg::A_ERR_L,
        csm_pkg::A_ERR_H, csm_pkg::A_BT_L, csm_pkg::A_BT_H, csm_pkg::A_IID_L, csm_pkg::A_IID_H,
        csm_pkg::A_TEST, csm_pkg::A_BRPE, csm_pkg::A_CLK_CFG};
    logic [7:0] gat [4] = '{csm_pkg::A_BT_L, csm_pkg::A_BT_H, csm_pkg::A_BRPE, csm_pkg::A_TEST};
    always #2.5 core_clk = ~core_clk;
    csm_can_sfr_map u_csm_can_sfr_map (.core_clk(core_clk), .rst(rst),
        .register_page_select(page), .sfr_req(req), .sfr_rdata(rdata), .sfr_hit(hit),
        .core_err_count(err), .core_int_id(iid), .core_status(8'h00), .core_status_load(1'b0),
        .can_rx(rx), .core_wr(cwr), .control_out(ctl), .bit_timing_out(bt),
        .prescaler_ext_out(brpe), .test_out(tst), .can_clock_config(ccfg));
    csm_core_model u_csm_core_model (.core_clk(core_clk), .rst(rst), .core_wr(cwr),
        .err_count(err), .int_id(iid), .can_rx(rx));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : end_of_test
    // one strobe cycle; the answer is settled at the following falling edge
    task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(negedge core_clk);
        req <= '{wr: w, rd: ~w, addr: a, wdata: d};
        @(negedge core_clk);
        req <= '0;
    endtask : acc
    function automatic logic [7:0] mrd(input logic [7:0] a);
        if (page !== csm_pkg::CAN_PAGE || !mp[a]) return 8'h00;
        case (a)
            csm_pkg::A_ERR_L: return err[7:0];
            csm_pkg::A_ERR_H: return err[15:8];
            csm_pkg::A_IID_L: return iid[7:0];
            csm_pkg::A_IID_H: return iid[15:8];
            csm_pkg::A_TEST:  return {rx, m[a][6:0]};
            default:          return m[a];
        endcase
    endfunction : mrd
    task automatic rd(input logic [7:0] a);
        acc(1'b0, a, 8'h00);
        check({8'h00, rdata}, {8'h00, mrd(a)});
        check({15'h0000, hit}, {15'h0000, page == csm_pkg::CAN_PAGE && mp[a]});
    endtask : rd
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        acc(1'b1, a, d);
        if (page !== csm_pkg::CAN_PAGE || !mp[a] || a inside {8'h96, 8'h97, 8'h9c, 8'h9d}) return;
        if (a inside {8'h9a, 8'h9b, 8'ha1} && !m[csm_pkg::A_CONTROL][csm_pkg::CFG_CHG_BIT]) return;
        if (a == csm_pkg::A_TEST && !m[csm_pkg::A_CONTROL][csm_pkg::TEST_BIT]) return;
        m[a] = (a == csm_pkg::A_TEST) ? (d & 8'h7f) : d;
    endtask : wr
    initial begin
        for (i = 0; i < 256; i++) begin
            m[i] = 8'h00;
            mp[i] = 1'b0;
        end
        foreach (regs[i]) mp[regs[i]] = 1'b1;
        for (i = 0; i < csm_pkg::N_IFR; i++) begin
            mp[csm_pkg::IFR_LO_ADDR[i]] = 1'b1;
            mp[csm_pkg::IFR_HI_ADDR[i]] = 1'b1;
            m[csm_pkg::IFR_LO_ADDR[i]] = csm_pkg::IFR_RESET[i][7:0];
            m[csm_pkg::IFR_HI_ADDR[i]] = csm_pkg::IFR_RESET[i][15:8];
        end
        m[csm_pkg::A_CONTROL] = csm_pkg::RST_CONTROL;
        m[csm_pkg::A_BT_L] = csm_pkg::RST_BT[7:0];
        m[csm_pkg::A_BT_H] = csm_pkg::RST_BT[15:8];
        repeat (12) @(negedge core_clk);
        rst <= 1'b0;
        page <= csm_pkg::CAN_PAGE;
        // reset values of every byte, unmapped places read zero
        for (k = 0; k < 256; k++) rd(k[7:0]);
        // each setting of the two write-enable bits against the gated registers
        for (k = 0; k < 4; k++) begin
            wr(csm_pkg::A_CONTROL, {k[1:0], 6'h01});
            foreach (gat[i]) begin
                v = 8'($random(seed));
                wr(gat[i], v);
                rd(gat[i]);
            end
        end
        page <= 8'h0b;
        foreach (regs[i]) begin
            v = 8'($random(seed));
            wr(regs[i], v);
            rd(regs[i]);
        end
        page <= csm_pkg::CAN_PAGE;
        // random bytes everywhere, read-only and unmapped places among them
        for (k = 0; k < 256; k++) begin
            v = 8'($random(seed));
            wr(k[7:0], v);
        end
        for (k = 0; k < 256; k++) rd(k[7:0]);
        end_of_test();
    end
    initial begin
        #100000;
        bad_count++;
        end_of_test();
    end
endmodule : test_can_sfr_register_map
